// File: hdl/gio_pin_unit.v
/*
  general-purpose pin unit: 104 pins in seven banks, two banks per register word except bank 6 alone in the last,
  atomic set/clear of the output state of output pins, pin level readback, rising-edge interrupts.
  assumes a plain strobe register port driven from mclk and pins sampled on mclk.
*/
`timescale 1ns/1ps
`include "gio_consts.vh"

module gio_pin_unit (
  input wire mclk,
  input wire rst_n,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire [103:0] pin_in,
  output wire [103:0] pin_out,
  output wire [103:0] pin_oe,
  output wire irq
);

  // ************************************************************
  // state
  // ************************************************************
  reg [103:0] dir;
  reg [103:0] out_state;
  reg [103:0] rise_en;
  reg [103:0] irq_stat;
  reg [103:0] irq_mask;
  reg [103:0] sync_a;
  reg [103:0] sync_b;
  reg [103:0] level_q;
  reg [103:0] next_dir;
  reg [103:0] next_out_state;
  reg [103:0] next_rise_en;
  reg [103:0] next_irq_stat;
  reg [103:0] next_irq_mask;
  reg [127:0] rd_vec;
  reg [31:0] next_rdata;

  // ************************************************************
  // address decode
  // ************************************************************
  wire [3:0] grp;
  wire [1:0] wrd;
  wire [127:0] word_hit;
  wire [103:0] wmask;
  wire [103:0] wbits;
  wire [103:0] out_pins;
  wire [103:0] level;
  wire [103:0] rise_evt;
  wire wr_dir;
  wire wr_outv;
  wire wr_oset;
  wire wr_oclr;
  wire wr_rset;
  wire wr_rclr;
  wire wr_istat;
  wire wr_imask;

  assign grp = reg_addr[`GIO_GRP_HI:`GIO_GRP_LO];
  assign wrd = reg_addr[`GIO_WRD_HI:`GIO_WRD_LO];

  // odd bank in the upper half, even bank in the lower half of each word
  assign word_hit = {{32{wrd == `GIO_WRD_B6}}, {32{wrd == `GIO_WRD_B45}},
                     {32{wrd == `GIO_WRD_B23}}, {32{wrd == `GIO_WRD_B01}}};
  // bits above pin 103 are cut off, so bank-6 bits 31-8 ignore writes
  assign wmask = word_hit[103:0];
  assign wbits = wmask & {reg_wdata[7:0], reg_wdata, reg_wdata, reg_wdata};

  assign wr_dir = reg_wr && (grp == `GIO_GRP_DIR);
  assign wr_outv = reg_wr && (grp == `GIO_GRP_OUTV);
  assign wr_oset = reg_wr && (grp == `GIO_GRP_OSET);
  assign wr_oclr = reg_wr && (grp == `GIO_GRP_OCLR);
  assign wr_rset = reg_wr && (grp == `GIO_GRP_RSET);
  assign wr_rclr = reg_wr && (grp == `GIO_GRP_RCLR);
  assign wr_istat = reg_wr && (grp == `GIO_GRP_ISTAT);
  assign wr_imask = reg_wr && (grp == `GIO_GRP_IMASK);

  // ************************************************************
  // pins
  // ************************************************************
  // set/clear only reach pins configured as outputs
  assign out_pins = ~dir;
  assign pin_out = out_state;
  // direction zero drives the pin, one leaves it as input
  assign pin_oe = out_pins;

  // inputs read the synchronised level, outputs the driven level
  // a one on the pin reads as one, so no inversion here
  assign level = (dir & sync_b) | (out_pins & out_state);

  // edge taken from the level, so an output pin toggled by software also counts
  assign rise_evt = rise_en & level & ~level_q;

  // ************************************************************
  // next-state of the software-visible bits
  // ************************************************************
  always @* begin
    next_dir = dir;
    next_out_state = out_state;
    next_rise_en = rise_en;
    next_irq_mask = irq_mask;
    if (wr_dir) begin
      next_dir = (dir & ~wmask) | wbits;
    end
    // one shared output state for all three write paths
    if (wr_outv) begin
      next_out_state = (out_state & ~wmask) | wbits;
    end
    // zero bits of the write leave the state alone
    if (wr_oset) begin
      next_out_state = next_out_state | (wbits & out_pins);
    end
    // clear evaluated last, so it wins should both ever coincide
    if (wr_oclr) begin
      next_out_state = next_out_state & ~(wbits & out_pins);
    end
    if (wr_rset) begin
      next_rise_en = next_rise_en | wbits;
    end
    if (wr_rclr) begin
      next_rise_en = next_rise_en & ~wbits;
    end
    if (wr_imask) begin
      next_irq_mask = (irq_mask & ~wmask) | wbits;
    end
  end

  // new edges win over a write-one-to-clear in the same cycle
  always @* begin
    next_irq_stat = irq_stat;
    if (wr_istat) begin
      next_irq_stat = irq_stat & ~wbits;
    end
    next_irq_stat = next_irq_stat | rise_evt;
  end

  // ************************************************************
  // registers
  // ************************************************************
  always @(posedge mclk) begin
    if (!rst_n) begin
      dir <= `GIO_RST_DIR;
      out_state <= `GIO_RST_ZERO;
      rise_en <= `GIO_RST_ZERO;
      irq_stat <= `GIO_RST_ZERO;
      irq_mask <= `GIO_RST_ZERO;
    end else begin
      dir <= next_dir;
      out_state <= next_out_state;
      rise_en <= next_rise_en;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
    end
  end

  // two-stage synchroniser; only sync_b is looked at
  always @(posedge mclk) begin
    if (!rst_n) begin
      sync_a <= `GIO_RST_ZERO;
      sync_b <= `GIO_RST_ZERO;
      level_q <= `GIO_RST_ZERO;
    end else begin
      sync_a <= pin_in;
      sync_b <= sync_a;
      level_q <= level;
    end
  end

  // ************************************************************
  // interrupt
  // ************************************************************
  assign irq = |(irq_stat & irq_mask);

  // ************************************************************
  // read path
  // ************************************************************
  // unused upper pad keeps bank-6 bits 31-8 and unmapped reads at zero
  always @* begin
    case (grp)
      `GIO_GRP_DIR: begin
        rd_vec = {24'h000000, dir};
      end
      `GIO_GRP_OUTV: begin
        rd_vec = {24'h000000, out_state};
      end
      `GIO_GRP_OSET, `GIO_GRP_OCLR: begin
        rd_vec = {24'h000000, out_state};
      end
      `GIO_GRP_LVL: begin
        rd_vec = {24'h000000, level};
      end
      `GIO_GRP_RSET, `GIO_GRP_RCLR: begin
        rd_vec = {24'h000000, rise_en};
      end
      `GIO_GRP_ISTAT: begin
        rd_vec = {24'h000000, irq_stat};
      end
      `GIO_GRP_IMASK: begin
        rd_vec = {24'h000000, irq_mask};
      end
      default: begin
        rd_vec = {128{1'b0}};
      end
    endcase
  end

  always @* begin
    case (wrd)
      `GIO_WRD_B01: begin
        next_rdata = rd_vec[31:0];
      end
      `GIO_WRD_B23: begin
        next_rdata = rd_vec[63:32];
      end
      `GIO_WRD_B45: begin
        next_rdata = rd_vec[95:64];
      end
      default: begin
        next_rdata = rd_vec[127:96];
      end
    endcase
  end

  // read data stand only in the cycle after the strobe
  always @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata <= `GIO_RST_RDATA;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= `GIO_RST_RDATA;
    end
  end

endmodule

// File: hdl/gio_consts.vh
/*
  register map, field layout and reset values of the general-purpose pin unit.
  assumes byte addressing on an 8-bit register address, one 32-bit word per register.
*/
`ifndef GIO_CONSTS_VH
`define GIO_CONSTS_VH

// ************************************************************
// geometry
// ************************************************************
`define GIO_NPINS 104
`define GIO_PADW 128
`define GIO_ADDR_W 8
`define GIO_DATA_W 32

// ************************************************************
// address fields: group in [7:4], word (bank pair) in [3:2]
// ************************************************************
`define GIO_GRP_HI 7
`define GIO_GRP_LO 4
`define GIO_WRD_HI 3
`define GIO_WRD_LO 2

// ************************************************************
// group codes, byte offset = group * 16 + word * 4
// ************************************************************
`define GIO_GRP_DIR 4'h1
`define GIO_GRP_OUTV 4'h2
`define GIO_GRP_OSET 4'h3
`define GIO_GRP_OCLR 4'h4
`define GIO_GRP_LVL 4'h5
`define GIO_GRP_RSET 4'h6
`define GIO_GRP_RCLR 4'h7
`define GIO_GRP_ISTAT 4'h8
`define GIO_GRP_IMASK 4'h9

// ************************************************************
// word codes
// ************************************************************
`define GIO_WRD_B01 2'h0
`define GIO_WRD_B23 2'h1
`define GIO_WRD_B45 2'h2
`define GIO_WRD_B6 2'h3

// ************************************************************
// reset values
// ************************************************************
`define GIO_RST_DIR {104{1'b1}}
`define GIO_RST_ZERO {104{1'b0}}
`define GIO_RST_RDATA 32'h00000000

`endif

// File: tb/gio_pin_unit_assertions.sv
/* checker for the pin unit: register port timing, drive state, level readback.
   assumes a bind to gio_pin_unit, one clock mclk, synchronous reset rst_n. */
`timescale 1ns/1ps
module gio_pin_unit_assertions (
  input wire mclk,
  input wire rst_n,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  input wire [103:0] pin_in,
  input wire [103:0] pin_out,
  input wire [103:0] pin_oe,
  input wire irq
);
  // ****************************************
  // pin 0 stands for all pins of the word
  // ****************************************
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_reset_state: assert property (
    $rose(rst_n) |-> pin_oe == 104'h0 && !irq) else $error("reset state");
  a_set_high: assert property (
    reg_wr && reg_addr == 8'h30 && reg_wdata[0] && pin_oe[0] |=> pin_out[0]) else $error("set");
  a_clear_low: assert property (
    reg_wr && reg_addr == 8'h40 && reg_wdata[0] && pin_oe[0] |=> !pin_out[0]) else $error("clr");
  a_input_locked: assert property (
    reg_wr && (reg_addr == 8'h30 || reg_addr == 8'h40) && !pin_oe[0]
    |=> pin_out[0] == $past(pin_out[0])) else $error("locked");
  a_clear_readback: assert property (
    reg_rd && reg_addr == 8'h40 |=> reg_rdata[0] == $past(pin_out[0])) else $error("readback");
  a_bank6_zero: assert property (
    reg_rd && reg_addr[3:2] == 2'h3 |=> reg_rdata[31:8] == 24'h0) else $error("bank6");
  a_level_sync: assert property (
    reg_rd && reg_addr == 8'h50 && !pin_oe[0] |=> reg_rdata[0] == $past(pin_in[0], 3))
    else $error("level in");
  a_level_drive: assert property (
    reg_rd && reg_addr == 8'h50 && pin_oe[0] |=> reg_rdata[0] == $past(pin_out[0]))
    else $error("level out");
  c_irq: cover property ($rose(irq));
  c_set: cover property (reg_wr && reg_addr == 8'h30 && pin_oe[0]);
  c_level: cover property (reg_rd && reg_addr == 8'h50 && !pin_oe[0]);
endmodule

// File: tb/gio_board_model.sv
/* board around the pins: the wire follows the unit where it drives, else the bench.
   assumes the bench sets ext_level with nonblocking assignments on the clock edge. */
`timescale 1ns/1ps
module gio_board_model (
  input wire [103:0] pin_out,
  input wire [103:0] pin_oe,
  input wire [103:0] ext_level,
  output wire [103:0] pin_in
);
  // no contention modelled: an enabled driver always wins the wire
  assign pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule

// File: tb/testbench.sv
/* self-checking bench: random register traffic against a bit-vector model.
   assumes gio_pin_unit, gio_board_model and the checker are compiled first. */
`timescale 1ns/1ps
module testbench;
  logic mclk = 0;
  logic rst_n = 0;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 0;
  logic reg_rd = 0;
  logic [31:0] reg_rdata;
  logic [103:0] pin_in, pin_out, pin_oe;
  logic [103:0] ext_level = 104'h0;
  logic irq;
  logic [127:0] m_dir = '1, m_out = 0, m_ris = 0, e;
  logic [31:0] d, dm;
  logic [7:0] grp [8] = '{8'h10, 8'h20, 8'h30, 8'h40, 8'h60, 8'h70, 8'h50, 8'ha0};
  integer error_cnt = 0, checked = 0, cyc = 0, i, w, op;
  gio_pin_unit i_gio_pin_unit (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));
  gio_board_model i_gio_board_model (.pin_out(pin_out), .pin_oe(pin_oe),
    .ext_level(ext_level), .pin_in(pin_in));
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  function automatic [31:0] wrd(input [127:0] v, input integer k);
    wrd = (k == 3) ? {24'h0, v[103:96]} : v[k*32 +: 32];
  endfunction
  task automatic chk(input [31:0] g, input [31:0] x);
    checked++;
    if (g !== x) begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic wr(input [7:0] a, input [31:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input [7:0] a, input [31:0] x);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, x);
  endtask
  task complete_run;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ****************************************
  // hang guard, well above the run length
  // ****************************************
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      $display("MISMATCH %0t timeout", $time);
      complete_run();
    end
  end
  initial begin
    d = $urandom(89);
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    for (w = 0; w < 4; w++) begin
      rd(8'h10 + 8'(4 * w), w == 3 ? 32'hff : 32'hffffffff);
      for (i = 2; i < 7; i++) rd(grp[i] + 8'(4 * w), 32'h0);
    end
    $display("test reset done");
    e = {$urandom, $urandom, $urandom, $urandom};
    @(posedge mclk) ext_level <= e[103:0];
    for (i = 0; i < 60; i++) begin
      w = $urandom % 4;
      op = $urandom % 8;
      d = $urandom;
      dm = d & (w == 3 ? 32'hff : 32'hffffffff);
      case (op)
        0: m_dir[w*32 +: 32] = dm;
        1: m_out[w*32 +: 32] = dm;
        2: m_out[w*32 +: 32] = m_out[w*32 +: 32] | (dm & ~m_dir[w*32 +: 32]);
        3: m_out[w*32 +: 32] = m_out[w*32 +: 32] & ~(dm & ~m_dir[w*32 +: 32]);
        4: m_ris[w*32 +: 32] = m_ris[w*32 +: 32] | dm;
        5: m_ris[w*32 +: 32] = m_ris[w*32 +: 32] & ~dm;
        default: ;
      endcase
      wr(grp[op] + 8'(4 * w), d);
      chk(wrd({24'h0, pin_oe}, w), wrd(~m_dir, w));
      chk(wrd({24'h0, pin_out}, w), wrd(m_out, w));
      rd(8'h30 + 8'(4 * w), wrd(m_out, w));
      rd(8'h40 + 8'(4 * w), wrd(m_out, w));
      rd(8'h20 + 8'(4 * w), wrd(m_out, w));
      rd(8'h50 + 8'(4 * w), wrd((m_dir & {24'h0, ext_level}) | (~m_dir & m_out), w));
      rd(8'h60 + 8'(4 * w), wrd(m_ris, w));
      rd(8'h70 + 8'(4 * w), wrd(m_ris, w));
      rd(8'ha0, 32'h0);
    end
    $display("test registers done");
    // pin 0 output, pin 1 input: set and clear must reach pin 0 only
    wr(8'h10, 32'hfffffffe);
    wr(8'h20, 32'h0);
    wr(8'h30, 32'h3);
    chk(pin_oe[31:0], 32'h1);
    rd(8'h30, 32'h1);
    rd(8'h50, (ext_level[31:0] & 32'hfffffffe) | 32'h1);
    wr(8'h40, 32'h3);
    rd(8'h40, 32'h0);
    chk(pin_out[31:0], 32'h0);
    $display("test set clear done");
    for (w = 0; w < 4; w++) wr(8'h70 + 8'(4 * w), 32'hffffffff);
    wr(8'h10, 32'hffffffff);
    @(posedge mclk) ext_level[0] <= 1'b0;
    repeat (4) @(posedge mclk);
    for (w = 0; w < 4; w++) wr(8'h80 + 8'(4 * w), 32'hffffffff);
    wr(8'h60, 32'h1);
    wr(8'h90, 32'h1);
    chk({31'h0, irq}, 32'h0);
    @(posedge mclk) ext_level[0] <= 1'b1;
    repeat (4) @(posedge mclk);
    #1 chk({31'h0, irq}, 32'h1);
    wr(8'h90, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(8'h90, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(8'h80, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(8'h70, 32'h1);
    rd(8'h60, 32'h0);
    @(posedge mclk) ext_level[0] <= 1'b0;
    repeat (4) @(posedge mclk);
    ext_level[0] <= 1'b1;
    repeat (4) @(posedge mclk);
    #1 chk({31'h0, irq}, 32'h0);
    $display("test interrupt done");
    complete_run();
  end
endmodule
bind gio_pin_unit gio_pin_unit_assertions i_chk (.mclk(mclk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));
